/* File: design/pbcpc_pkg.sv */
// constants for the port b / port c pin control block
// assumes an 8-bit register port and one 100 MHz clock
package pbcpc_pkg;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;
	// register offsets on the plain register port
	localparam logic [3:0] OFS_ANALOG_SELECT_B = 4'h0;
	localparam logic [3:0] OFS_OUTPUT_LATCH_B = 4'h1;
	localparam logic [3:0] OFS_PIN_LEVEL_B = 4'h2;
	localparam logic [3:0] OFS_DIRECTION_B = 4'h3;
	localparam logic [3:0] OFS_PULLUP_ENABLE_B = 4'h4;
	localparam logic [3:0] OFS_PIN_LEVEL_C = 4'h5;
	localparam logic [3:0] OFS_OUTPUT_LATCH_C = 4'h6;
	localparam logic [3:0] OFS_DIRECTION_C = 4'h7;
	localparam logic [3:0] OFS_ALT_PIN_FUNC = 4'h8;
	localparam logic [3:0] OFS_DEVICE_CONFIG = 4'h9;
	// implemented bits and field positions
	localparam logic [7:0] ANALOG_B_MASK = 8'h3f;
	localparam int unsigned CAPTURE2_SEL_BIT = 0;
	localparam int unsigned PKG28_BIT = 0;
	localparam int unsigned DEBUG_EN_BIT = 1;
	localparam logic [7:0] ALT_PIN_MASK = 8'h01;
	localparam logic [7:0] CONFIG_MASK = 8'h03;
	// reset values
	localparam logic [7:0] RST_ANALOG_SELECT_B = 8'h3f;
	localparam logic [7:0] RST_DIRECTION = 8'hff;
	localparam logic [7:0] RST_PULLUP_B = 8'hff;
	localparam logic [7:0] RST_LATCH = 8'h00;
	localparam logic [7:0] RST_ALT_PIN = 8'h00;
	localparam logic [7:0] RST_CONFIG = 8'h01;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [2:0] RST_SYNC = 3'h0;
	// width of the priority list including the latch slot
	localparam int unsigned PRIO_W = 5;
endpackage

/* File: design/pbcpc_top.sv */
// port b and port c pin control: direction, latches, pin sampling,
// analog select of port b and output priority between peripherals.
// assumes pins are resolved outside from value and enable, and that
// the register master keeps the one-cycle strobe protocol.
`timescale 1ns/1ps
module pbcpc_top
	import pbcpc_pkg::*;
(
	input wire logic clock_i, // 100 MHz system clock
	input wire logic nrst_i, // async reset, active low
	// register port
	input wire logic [3:0] addr_i, // register offset
	input wire logic [7:0] wdata_i, // write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	output logic [7:0] rdata_o, // read data, cycle after strobe
	// pins
	input wire logic [7:0] pin_b_i, // port b pin levels
	output logic [7:0] pin_b_o, // port b drive value
	output logic [7:0] pin_b_oe_o, // port b drive enable
	output logic [7:0] pullup_b_o, // port b weak pull-up on
	output logic [5:0] analog_b_o, // port b pins in analog mode
	input wire logic [7:0] pin_c_i, // port c pin levels
	output logic [7:0] pin_c_o, // port c drive value
	output logic [7:0] pin_c_oe_o, // port c drive enable
	// competing peripheral outputs
	input wire logic [15:0] seg_en_i, // display segment enables
	input wire logic [15:0] seg_val_i, // display segment values
	input wire logic [1:0] com_en_i, // display common enables
	input wire logic [1:0] com_val_i, // display common values
	input wire logic capture_compare_4_en_i, // capture/compare 4 enable
	input wire logic capture_compare_4_val_i, // capture/compare 4 value
	input wire logic ccp2_en_i, // capture/compare 2 or pwm 2a enable
	input wire logic ccp2_val_i, // capture/compare 2 or pwm 2a value
	input wire logic pwm1a_en_i, // pwm 1a enable
	input wire logic pwm1a_val_i, // pwm 1a value
	input wire logic pwm1b_en_i, // pwm 1b enable
	input wire logic pwm1b_val_i, // pwm 1b value
	input wire logic pwm1c_en_i, // pwm 1c enable
	input wire logic pwm1c_val_i, // pwm 1c value
	input wire logic pwm1d_en_i, // pwm 1d enable
	input wire logic pwm1d_val_i, // pwm 1d value
	input wire logic pwm2b_en_i, // pwm 2b enable
	input wire logic pwm2b_val_i, // pwm 2b value
	input wire logic pwm3a_en_i, // pwm 3a enable
	input wire logic pwm3a_val_i, // pwm 3a value
	input wire logic pwm3b_en_i, // pwm 3b enable
	input wire logic pwm3b_val_i, // pwm 3b value
	input wire logic prog_clk_en_i, // serial programming clock enable
	input wire logic prog_clk_val_i, // serial programming clock value
	input wire logic prog_dat_en_i, // serial programming data enable
	input wire logic prog_dat_val_i, // serial programming data value
	input wire logic dbg_clk_en_i, // debug clock enable
	input wire logic dbg_clk_val_i, // debug clock value
	input wire logic dbg_dat_en_i, // debug data enable
	input wire logic dbg_dat_val_i, // debug data value
	input wire logic timer1_osc_out_en_i, // timer1 oscillator out enable
	input wire logic timer1_osc_out_val_i, // timer1 oscillator out value
	input wire logic timer1_osc_in_en_i, // timer1 oscillator in enable
	input wire logic timer1_osc_in_val_i, // timer1 oscillator in value
	input wire logic scl_en_i, // i2c clock enable
	input wire logic scl_val_i, // i2c clock value
	input wire logic sda_en_i, // i2c data enable
	input wire logic sda_val_i, // i2c data value
	input wire logic sck_en_i, // spi clock enable
	input wire logic sck_val_i, // spi clock value
	input wire logic sdo_en_i, // serial data out enable
	input wire logic sdo_val_i, // serial data out value
	input wire logic tx_en_i, // uart transmit enable
	input wire logic tx_val_i, // uart transmit value
	input wire logic sync_clk_en_i, // synchronous serial clock enable
	input wire logic sync_clk_val_i, // synchronous serial clock value
	input wire logic sync_dat_en_i, // synchronous serial data enable
	input wire logic sync_dat_val_i // synchronous serial data value
);

	// first enabled slot wins; slot 0 is the highest priority
	function automatic logic pick(input logic [4:0] en, input logic [4:0] val);
		logic r;
		r = 1'b0;
		for (int i = PRIO_W - 1; i >= 0; i--) begin
			if (en[i]) begin
				r = val[i];
			end
		end
		return r;
	endfunction

	// three-stage sampler, a bit changes once stages 2 and 3 agree
	function automatic logic [7:0] settle(input logic [7:0] s2, input logic [7:0] s3,
		input logic [7:0] cur);
		return (s2 & s3) | (cur & (s2 ^ s3));
	endfunction

	// software registers
	logic [7:0] analog_select_b;
	logic [7:0] output_latch_b;
	logic [7:0] direction_b;
	logic [7:0] pullup_enable_b;
	logic [7:0] output_latch_c;
	logic [7:0] direction_c;
	logic [7:0] alternate_pin_function_control;
	logic [7:0] device_config;

	// pin samplers
	logic [7:0] sb1, sb2, sb3, pin_b_seen;
	logic [7:0] sc1, sc2, sc3, pin_c_seen;

	// decoded strobes
	wire logic wr_ansel = wr_i && (addr_i == OFS_ANALOG_SELECT_B);
	wire logic wr_lat_b = wr_i && ((addr_i == OFS_OUTPUT_LATCH_B) ||
		(addr_i == OFS_PIN_LEVEL_B));
	wire logic wr_dir_b = wr_i && (addr_i == OFS_DIRECTION_B);
	wire logic wr_pull_b = wr_i && (addr_i == OFS_PULLUP_ENABLE_B);
	wire logic wr_lat_c = wr_i && ((addr_i == OFS_OUTPUT_LATCH_C) ||
		(addr_i == OFS_PIN_LEVEL_C));
	wire logic wr_dir_c = wr_i && (addr_i == OFS_DIRECTION_C);
	wire logic wr_apf = wr_i && (addr_i == OFS_ALT_PIN_FUNC);
	wire logic wr_cfg = wr_i && (addr_i == OFS_DEVICE_CONFIG);

	// configuration bits
	wire logic pkg28 = device_config[PKG28_BIT];
	wire logic dbg_on = device_config[DEBUG_EN_BIT];
	wire logic ccp2_on_b = alternate_pin_function_control[CAPTURE2_SEL_BIT];

	// digital reads: analog pins read zero, their input buffer is off
	wire logic [7:0] read_pin_b = pin_b_seen & ~analog_select_b;
	wire logic [7:0] read_pin_c = pin_c_seen;

	// read mux; unmapped offsets answer zero
	logic [7:0] next_rdata;
	always_comb begin
		case (addr_i)
			OFS_ANALOG_SELECT_B: next_rdata = analog_select_b & ANALOG_B_MASK;
			OFS_OUTPUT_LATCH_B: next_rdata = output_latch_b;
			OFS_PIN_LEVEL_B: next_rdata = read_pin_b;
			OFS_DIRECTION_B: next_rdata = direction_b;
			OFS_PULLUP_ENABLE_B: next_rdata = pullup_enable_b;
			OFS_PIN_LEVEL_C: next_rdata = read_pin_c;
			OFS_OUTPUT_LATCH_C: next_rdata = output_latch_c;
			OFS_DIRECTION_C: next_rdata = direction_c;
			OFS_ALT_PIN_FUNC: next_rdata = alternate_pin_function_control;
			OFS_DEVICE_CONFIG: next_rdata = device_config;
			default: next_rdata = RST_ZERO;
		endcase
	end

	// port b output priority; 28-pin only functions gated by package bit
	logic [7:0] next_pin_b;
	assign next_pin_b[0] = pick({1'b1, 1'b0, 1'b0, capture_compare_4_en_i & pkg28, seg_en_i[0]},
		{output_latch_b[0], 2'b00, capture_compare_4_val_i, seg_val_i[0]});
	assign next_pin_b[1] = pick({1'b1, 3'b000, pwm1c_en_i & pkg28},
		{output_latch_b[1], 3'b000, pwm1c_val_i});
	assign next_pin_b[2] = pick({1'b1, 3'b000, pwm1b_en_i & pkg28},
		{output_latch_b[2], 3'b000, pwm1b_val_i});
	assign next_pin_b[3] = pick({1'b1, 3'b000, ccp2_en_i & ccp2_on_b},
		{output_latch_b[3], 3'b000, ccp2_val_i});
	assign next_pin_b[4] = pick({1'b1, 2'b00, pwm1d_en_i & pkg28, com_en_i[0]},
		{output_latch_b[4], 2'b00, pwm1d_val_i, com_val_i[0]});
	assign next_pin_b[5] = pick({1'b1, 1'b0, pwm3a_en_i, pwm2b_en_i & pkg28, com_en_i[1]},
		{output_latch_b[5], 1'b0, pwm3a_val_i, pwm2b_val_i, com_val_i[1]});
	assign next_pin_b[6] = pick({1'b1, 1'b0, seg_en_i[14], dbg_clk_en_i & dbg_on,
		prog_clk_en_i},
		{output_latch_b[6], 1'b0, seg_val_i[14], dbg_clk_val_i, prog_clk_val_i});
	assign next_pin_b[7] = pick({1'b1, 1'b0, seg_en_i[13], dbg_dat_en_i & dbg_on,
		prog_dat_en_i},
		{output_latch_b[7], 1'b0, seg_val_i[13], dbg_dat_val_i, prog_dat_val_i});

	// port c output priority
	logic [7:0] next_pin_c;
	assign next_pin_c[0] = pick({1'b1, 2'b00, pwm2b_en_i, timer1_osc_out_en_i},
		{output_latch_c[0], 2'b00, pwm2b_val_i, timer1_osc_out_val_i});
	assign next_pin_c[1] = pick({1'b1, 2'b00, ccp2_en_i & ~ccp2_on_b, timer1_osc_in_en_i},
		{output_latch_c[1], 2'b00, ccp2_val_i, timer1_osc_in_val_i});
	assign next_pin_c[2] = pick({1'b1, 2'b00, pwm1a_en_i, seg_en_i[3]},
		{output_latch_c[2], 2'b00, pwm1a_val_i, seg_val_i[3]});
	assign next_pin_c[3] = pick({1'b1, 1'b0, sck_en_i, scl_en_i, seg_en_i[6]},
		{output_latch_c[3], 1'b0, sck_val_i, scl_val_i, seg_val_i[6]});
	assign next_pin_c[4] = pick({1'b1, 2'b00, sda_en_i, seg_en_i[11]},
		{output_latch_c[4], 2'b00, sda_val_i, seg_val_i[11]});
	assign next_pin_c[5] = pick({1'b1, 2'b00, sdo_en_i, seg_en_i[10]},
		{output_latch_c[5], 2'b00, sdo_val_i, seg_val_i[10]});
	assign next_pin_c[6] = pick({1'b1, pwm3a_en_i & pkg28, sync_clk_en_i, tx_en_i,
		seg_en_i[9]},
		{output_latch_c[6], pwm3a_val_i, sync_clk_val_i, tx_val_i, seg_val_i[9]});
	assign next_pin_c[7] = pick({1'b1, 1'b0, pwm3b_en_i & pkg28, sync_dat_en_i,
		seg_en_i[8]},
		{output_latch_c[7], 1'b0, pwm3b_val_i, sync_dat_val_i, seg_val_i[8]});

	// drivers follow direction only; analog select does not gate outputs
	wire logic [7:0] next_oe_b = ~direction_b;
	wire logic [7:0] next_oe_c = ~direction_c;
	// pull-ups drop automatically while a pin drives
	wire logic [7:0] next_pullup_b = pullup_enable_b & direction_b;

	// control registers
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			analog_select_b <= RST_ANALOG_SELECT_B;
			direction_b <= RST_DIRECTION;
			direction_c <= RST_DIRECTION;
			output_latch_b <= RST_LATCH;
			output_latch_c <= RST_LATCH;
			pullup_enable_b <= RST_PULLUP_B;
			alternate_pin_function_control <= RST_ALT_PIN;
			device_config <= RST_CONFIG;
		end else begin
			if (wr_ansel) begin
				analog_select_b <= wdata_i & ANALOG_B_MASK;
			end
			if (wr_lat_b) begin
				output_latch_b <= wdata_i;
			end
			if (wr_dir_b) begin
				direction_b <= wdata_i;
			end
			if (wr_pull_b) begin
				pullup_enable_b <= wdata_i;
			end
			if (wr_lat_c) begin
				output_latch_c <= wdata_i;
			end
			if (wr_dir_c) begin
				direction_c <= wdata_i;
			end
			if (wr_apf) begin
				alternate_pin_function_control <= wdata_i & ALT_PIN_MASK;
			end
			if (wr_cfg) begin
				device_config <= wdata_i & CONFIG_MASK;
			end
		end
	end

	// pin samplers; stage one feeds stage two only
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sb1 <= RST_ZERO;
			sb2 <= RST_ZERO;
			sb3 <= RST_ZERO;
			pin_b_seen <= RST_ZERO;
			sc1 <= RST_ZERO;
			sc2 <= RST_ZERO;
			sc3 <= RST_ZERO;
			pin_c_seen <= RST_ZERO;
		end else begin
			sb1 <= pin_b_i;
			sb2 <= sb1;
			sb3 <= sb2;
			pin_b_seen <= settle(sb2, sb3, pin_b_seen);
			sc1 <= pin_c_i;
			sc2 <= sc1;
			sc3 <= sc2;
			pin_c_seen <= settle(sc2, sc3, pin_c_seen);
		end
	end

	// registered outputs; read data stands one cycle after the strobe
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_o <= RST_ZERO;
			pin_b_o <= RST_ZERO;
			pin_b_oe_o <= RST_ZERO;
			pullup_b_o <= RST_ZERO;
			analog_b_o <= RST_ANALOG_SELECT_B[5:0];
			pin_c_o <= RST_ZERO;
			pin_c_oe_o <= RST_ZERO;
		end else begin
			rdata_o <= rd_i ? next_rdata : RST_ZERO;
			pin_b_o <= next_pin_b;
			pin_b_oe_o <= next_oe_b;
			pullup_b_o <= next_pullup_b;
			analog_b_o <= analog_select_b[5:0];
			pin_c_o <= next_pin_c;
			pin_c_oe_o <= next_oe_c;
		end
	end

endmodule

/* File: tb/pbcpc_chk_sva.sv */
// checker on the pin control ports: register timing, enables, priority slots
// assumes one clock domain and only the top ports visible
`timescale 1ns/1ps
module pbcpc_chk
	import pbcpc_pkg::*;
(
	input wire logic clock_i, // clock
	input wire logic nrst_i, // reset, active low
	input wire logic [3:0] addr_i, // offset
	input wire logic [7:0] wdata_i, // write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	input wire logic [7:0] rdata_o, // read data
	input wire logic [7:0] pin_b_o, // pb drive
	input wire logic [5:0] analog_b_o, // pb analog
	input wire logic [7:0] pin_c_o, // pc drive
	input wire logic [7:0] pin_c_oe_o, // pc enable
	input wire logic [15:0] seg_en_i, // segment enables
	input wire logic [15:0] seg_val_i, // segment values
	input wire logic prog_clk_en_i, // prog clock enable
	input wire logic prog_clk_val_i, // prog clock value
	input wire logic timer1_osc_out_en_i, // osc out enable
	input wire logic timer1_osc_out_val_i // osc out value
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	// a write is taken, the register moves, the output copy follows one edge later
	sequence s_wr_ana; wr_i && addr_i == OFS_ANALOG_SELECT_B; endsequence
	sequence s_wr_dirc; wr_i && addr_i == OFS_DIRECTION_C; endsequence
	property p_ana_wr; s_wr_ana |-> ##2 analog_b_o == $past(wdata_i[5:0], 2); endproperty
	a_ana_wr: assert property (p_ana_wr) else $error("analog mode not taken");
	property p_ana_rd; rd_i && addr_i == OFS_ANALOG_SELECT_B |=> rdata_o[7:6] == 2'h0; endproperty
	a_ana_rd: assert property (p_ana_rd) else $error("analog upper bits set");
	property p_dirc; s_wr_dirc |-> ##2 pin_c_oe_o == ~$past(wdata_i, 2); endproperty
	a_dirc: assert property (p_dirc) else $error("port c enable wrong");
	// enables move only after a direction write, never with peripheral traffic
	property p_oe_hold; $changed(pin_c_oe_o) |-> $past(wr_i && addr_i == OFS_DIRECTION_C, 2);
	endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("enable moved alone");
	property p_display_segment_0; seg_en_i[0] |=> pin_b_o[0] == $past(seg_val_i[0]); endproperty
	a_display_segment_0: assert property (p_display_segment_0) else $error("pb0 top slot lost");
	property p_prog; prog_clk_en_i |=> pin_b_o[6] == $past(prog_clk_val_i); endproperty
	a_prog: assert property (p_prog) else $error("pb6 top slot lost");
	property p_osc; timer1_osc_out_en_i |=> pin_c_o[0] == $past(timer1_osc_out_val_i); endproperty
	a_osc: assert property (p_osc) else $error("pc0 top slot lost");
	property p_seg9; seg_en_i[9] |=> pin_c_o[6] == $past(seg_val_i[9]); endproperty
	a_seg9: assert property (p_seg9) else $error("pc6 top slot lost");
endmodule

bind pbcpc_top pbcpc_chk u_chk (.clock_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
	.pin_b_o, .analog_b_o, .pin_c_o, .pin_c_oe_o, .seg_en_i, .seg_val_i, .prog_clk_en_i,
	.prog_clk_val_i, .timer1_osc_out_en_i, .timer1_osc_out_val_i);

/* File: tb/pbcpc_pins.sv */
// board model: a pin shows the design drive when enabled, else the board level
// assumes the board never fights a driven pin
`timescale 1ns/1ps
module pbcpc_pins (
	input wire logic [7:0] drv_i, // design drive value
	input wire logic [7:0] oe_i, // design drive enable
	input wire logic [7:0] ext_i, // board level
	output logic [7:0] lvl_o // resolved pin level
);
	// board yields wherever the driver is on
	assign lvl_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the port b / port c pin control block
// assumes the one-cycle register port and registered pin outputs
`timescale 1ns/1ps
module tb_top;
	import pbcpc_pkg::*;
	logic clock_i = 1'b0, nrst_i = 1'b0, wr = 1'b0, rd = 1'b0, rd_q = 1'b0, s = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, eb = 8'h00, ec = 8'h00, rdata, pbo, pboe, pbi, pco, pcoe, pci;
	logic [7:0] d, dir, a;
	logic [21:0] fe = '0, fv = '0;
	logic [15:0] se = '0, sv = '0;
	logic [1:0] ce = '0, cv = '0;
	logic [31:0] lf = 32'h0001_4f6e, r;
	logic [7:0] exp_q[$];
	int mismatches = 0, samples_checked = 0;
	logic [3:0] ra[6] = '{OFS_ANALOG_SELECT_B, OFS_OUTPUT_LATCH_B, OFS_DIRECTION_B,
		OFS_OUTPUT_LATCH_C, OFS_DIRECTION_C, 4'hf};
	logic [7:0] rv[6] = '{RST_ANALOG_SELECT_B, RST_LATCH, RST_DIRECTION, RST_LATCH,
		RST_DIRECTION, RST_ZERO};

	always #5 clock_i = ~clock_i;

	pbcpc_top dut (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.rd_i(rd), .rdata_o(rdata), .pin_b_i(pbi), .pin_b_o(pbo), .pin_b_oe_o(pboe),
		.pullup_b_o(), .analog_b_o(), .pin_c_i(pci), .pin_c_o(pco), .pin_c_oe_o(pcoe),
		.seg_en_i(se), .seg_val_i(sv), .com_en_i(ce), .com_val_i(cv), .capture_compare_4_en_i(fe[0]),
		.capture_compare_4_val_i(fv[0]), .ccp2_en_i(fe[1]), .ccp2_val_i(fv[1]), .pwm1a_en_i(fe[2]),
		.pwm1a_val_i(fv[2]), .pwm1b_en_i(fe[3]), .pwm1b_val_i(fv[3]), .pwm1c_en_i(fe[4]),
		.pwm1c_val_i(fv[4]), .pwm1d_en_i(fe[5]), .pwm1d_val_i(fv[5]), .pwm2b_en_i(fe[6]),
		.pwm2b_val_i(fv[6]), .pwm3a_en_i(fe[7]), .pwm3a_val_i(fv[7]), .pwm3b_en_i(fe[8]),
		.pwm3b_val_i(fv[8]), .prog_clk_en_i(fe[9]), .prog_clk_val_i(fv[9]),
		.prog_dat_en_i(fe[10]), .prog_dat_val_i(fv[10]), .dbg_clk_en_i(fe[11]),
		.dbg_clk_val_i(fv[11]), .dbg_dat_en_i(fe[12]), .dbg_dat_val_i(fv[12]),
		.timer1_osc_out_en_i(fe[13]), .timer1_osc_out_val_i(fv[13]), .timer1_osc_in_en_i(fe[14]), .timer1_osc_in_val_i(fv[14]),
		.scl_en_i(fe[15]), .scl_val_i(fv[15]), .sda_en_i(fe[16]), .sda_val_i(fv[16]),
		.sck_en_i(fe[17]), .sck_val_i(fv[17]), .sdo_en_i(fe[18]), .sdo_val_i(fv[18]),
		.tx_en_i(fe[19]), .tx_val_i(fv[19]), .sync_clk_en_i(fe[20]), .sync_clk_val_i(fv[20]),
		.sync_dat_en_i(fe[21]), .sync_dat_val_i(fv[21]));
	pbcpc_pins u_pb (.drv_i(pbo), .oe_i(pboe), .ext_i(eb), .lvl_o(pbi));
	pbcpc_pins u_pc (.drv_i(pco), .oe_i(pcoe), .ext_i(ec), .lvl_o(pci));

	// 32 shifts per draw so that successive words are not mere shifts of each other
	function automatic logic [31:0] rnd();
		for (int i = 0; i < 32; i++) lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf;
	endfunction

	// port c pin winners, highest slot first
	function automatic logic [7:0] exp_c(input logic [7:0] l, input logic sel);
		exp_c[0] = fe[13] ? fv[13] : fe[6] ? fv[6] : l[0];
		exp_c[1] = fe[14] ? fv[14] : (fe[1] && !sel) ? fv[1] : l[1];
		exp_c[2] = se[3] ? sv[3] : fe[2] ? fv[2] : l[2];
		exp_c[3] = se[6] ? sv[6] : fe[15] ? fv[15] : fe[17] ? fv[17] : l[3];
		exp_c[4] = se[11] ? sv[11] : fe[16] ? fv[16] : l[4];
		exp_c[5] = se[10] ? sv[10] : fe[18] ? fv[18] : l[5];
		exp_c[6] = se[9] ? sv[9] : fe[19] ? fv[19] : fe[20] ? fv[20] : fe[7] ? fv[7] : l[6];
		exp_c[7] = se[8] ? sv[8] : fe[21] ? fv[21] : fe[8] ? fv[8] : l[7];
	endfunction

	// port b pin winners; 28-pin package on, debug off after reset
	function automatic logic [7:0] exp_b(input logic [7:0] l, input logic sel);
		exp_b[0] = se[0] ? sv[0] : fe[0] ? fv[0] : l[0];
		exp_b[1] = fe[4] ? fv[4] : l[1];
		exp_b[2] = fe[3] ? fv[3] : l[2];
		exp_b[3] = (fe[1] && sel) ? fv[1] : l[3];
		exp_b[4] = ce[0] ? cv[0] : fe[5] ? fv[5] : l[4];
		exp_b[5] = ce[1] ? cv[1] : fe[6] ? fv[6] : fe[7] ? fv[7] : l[5];
		exp_b[6] = fe[9] ? fv[9] : se[14] ? sv[14] : l[6];
		exp_b[7] = fe[10] ? fv[10] : se[13] ? sv[13] : l[7];
	endfunction

	// one bus cycle; on a read the data slot carries the expected answer
	task automatic op(input logic w, input logic rs, input logic [3:0] ad, input logic [7:0] dv);
		@(posedge clock_i);
		wr <= w;
		rd <= rs;
		addr <= ad;
		wdata <= dv;
		if (rs) exp_q.push_back(dv);
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] want);
		samples_checked++;
		if (got !== want) begin
			mismatches++;
			$display("mismatch at %0t: got %h want %h", $time, got, want);
		end
	endtask

	task automatic complete_run();
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// read data stands only in the cycle after the strobe
	always @(posedge clock_i) rd_q <= rd;
	always @(negedge clock_i) begin
		if (rd_q) check(rdata, exp_q.pop_front());
	end

	// main sequence
	initial begin
		repeat (4) @(posedge clock_i);
		nrst_i <= 1'b1;
		r = rnd();
		eb <= r[7:0]; // port b kept input while analog
		foreach (ra[i]) op(1'b0, 1'b1, ra[i], rv[i]);
		check(pcoe, 8'h00);
		a = r[15:8];
		op(1'b1, 1'b0, OFS_ANALOG_SELECT_B, a);
		op(1'b0, 1'b1, OFS_ANALOG_SELECT_B, a & ANALOG_B_MASK);
		op(1'b0, 1'b1, OFS_PIN_LEVEL_B, eb & ~(a & ANALOG_B_MASK));
		for (int k = 0; k < 24; k++) begin
			r = rnd();
			fe <= r[21:0];
			d = r[29:22];
			s = r[30];
			r = rnd();
			fv <= r[21:0];
			dir = r[31:24];
			r = rnd();
			se <= r[15:0];
			sv <= r[31:16];
			r = rnd();
			ec <= r[7:0];
			ce <= r[9:8];
			cv <= r[11:10];
			op(1'b1, 1'b0, OFS_DIRECTION_C, dir);
			op(1'b1, 1'b0, OFS_ALT_PIN_FUNC, {7'h00, s});
			op(1'b1, 1'b0, OFS_PIN_LEVEL_C, d);
			op(1'b0, 1'b1, OFS_OUTPUT_LATCH_C, d);
			op(1'b0, 1'b1, OFS_DIRECTION_C, dir);
			repeat (6) op(1'b0, 1'b0, 4'h0, 8'h00);
			check(pco, exp_c(d, s));
			check(pcoe, ~dir);
			check(pbo, exp_b(RST_LATCH, s));
			check(pboe, ~RST_DIRECTION);
			op(1'b0, 1'b1, OFS_PIN_LEVEL_C, (~dir & exp_c(d, s)) | (dir & ec));
		end
		repeat (3) op(1'b0, 1'b0, 4'h0, 8'h00);
		complete_run();
	end
endmodule
